// [common/emx_pkg.sv]
// constants, state codes and field positions for the external memory
// controller address mapper; assumes a 250 MHz single clock domain.
`default_nettype none
package emx_pkg;
   localparam int ROW_W = 13;                  // row / pin address width
   localparam int DAT_W = 16;                  // external data width
   localparam int NREG  = 4;                   // async regions
   localparam int NBANK = 4;                   // SDRAM internal banks
   localparam logic [4:0] BANK_LSB_BASE = 5'h09; // bank field at 9+size
   localparam logic [10:0] COL_MASK_FULL = 11'h7FF;
   localparam logic [1:0]  PAGE_TOP     = 2'h3;
   localparam logic [1:0]  DQM_IDLE     = 2'h3;  // masks high when idle
   localparam logic [1:0]  DQM_READ     = 2'h0;  // masks low on reads
   localparam logic [3:0]  CS_IDLE      = 4'hF;
   localparam logic [5:0]  CNT_RST      = 6'h00;
   localparam logic [9:0]  NAND_MAX     = 10'h200; // 512 bytes
   localparam int          WORD_LSB     = 2;   // byte bit of word addr
   localparam int          A22_SRC      = 24;  // word bit 22
   localparam int          A10_POS      = 10;  // auto-precharge pin

   typedef enum logic [6:0] {
      EMX_IDLE   = 7'h01,
      EMX_PRE    = 7'h02,
      EMX_ACT    = 7'h04,
      EMX_RW     = 7'h08,
      EMX_SETUP  = 7'h10,
      EMX_STROBE = 7'h20,
      EMX_HOLD   = 7'h40
   } emx_state_t;
endpackage
`default_nettype wire

// [core/emx_bank_trk.sv]
// open-row tracker for one SDRAM internal bank.
// assumes activate and precharge for this bank never fall in one cycle.
`timescale 1ns/100ps
`default_nettype none
module emx_bank_trk (
   // clock and reset
   input  wire logic                     clock,
   input  wire logic                     rst_b,
   // bank events
   input  wire logic                     open_set,
   input  wire logic                     close_clr,
   input  wire logic [emx_pkg::ROW_W-1:0] row_in,
   // tracked state
   output logic                          is_open,
   output logic [emx_pkg::ROW_W-1:0]     open_row
);
   import emx_pkg::*;

   // one row per bank: a new activate replaces, never adds
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         is_open  <= 1'b0;
         open_row <= '0;
      end else if (open_set) begin   // set wins over clear
         is_open  <= 1'b1;
         open_row <= row_in;
      end else if (close_clr) begin
         is_open  <= 1'b0;
      end
   end
endmodule // emx_bank_trk
`default_nettype wire

// [core/emx_ctrl.sv]
// SDRAM address mapper with open-bank tracking plus asynchronous
// region sequencer (normal / strobe-select, wait, NAND ECC).
// assumes the requester holds its request stable until ack.
`timescale 1ns/100ps
`default_nettype none
module emx_ctrl (
   // clock and reset
   input  wire logic                      clock,
   input  wire logic                      rst_b,
   // requester
   input  wire logic                      req,
   input  wire logic                      req_sdram,
   input  wire logic                      req_wr,
   input  wire logic [31:0]               req_addr,
   input  wire logic [1:0]                req_be,
   input  wire logic [emx_pkg::DAT_W-1:0] req_wdata,
   input  wire logic [1:0]                req_region,
   output logic                           ack,
   output logic [emx_pkg::DAT_W-1:0]      rd_data,
   // SDRAM configuration
   input  wire logic [1:0]                bank_count_field,
   input  wire logic [1:0]                page_size_field,
   input  wire logic                      sdram_large,
   // region configuration, one bit per region
   input  wire logic [emx_pkg::NREG-1:0]  region_strobe_sel,
   input  wire logic [emx_pkg::NREG-1:0]  region_ext_wait,
   input  wire logic [emx_pkg::NREG-1:0]  region_wide,
   input  wire logic [emx_pkg::NREG-1:0]  region_nand,
   input  wire logic [emx_pkg::NREG-1:0]  region_a22_en,
   // async cycle timing, each phase lasts value+1 cycles
   input  wire logic [5:0]                setup_cycles,
   input  wire logic [5:0]                strobe_cycles,
   input  wire logic [5:0]                hold_cycles,
   // NAND ECC
   input  wire logic                      ecc_clear,
   output logic [16:0]                    ecc_value,
   output logic [9:0]                     ecc_bytes,
   // SDRAM commands
   output logic                           sd_cmd_pre,
   output logic                           sd_cmd_act,
   output logic                           sd_cmd_read,
   output logic                           sd_cmd_write,
   output logic [emx_pkg::NBANK-1:0]      banks_open,
   // memory pins
   output logic [emx_pkg::ROW_W-1:0]      ext_addr_bus,
   output logic [1:0]                     bank_address_pins,
   output logic [1:0]                     byte_mask_pins,
   output logic [emx_pkg::NREG-1:0]       region_chip_selects_b,
   output logic                           write_strobe_b,
   output logic                           output_enable_strobe_b,
   input  wire logic                      wait_input,
   input  wire logic [emx_pkg::DAT_W-1:0] ext_data_in,
   output logic [emx_pkg::DAT_W-1:0]      ext_data_out,
   output logic                           ext_data_oe_b
);
   import emx_pkg::*;
   emx_state_t        state_r, state_nxt;     // sequencer state
   logic [5:0]        cnt_r, cnt_nxt;         // phase counter
   logic              wait_m_r, wait_s_r;     // wait synchroniser
   logic [DAT_W-1:0]  din_m_r, din_s_r;       // data synchroniser
   logic [16:0]       ecc_nxt;
   logic [9:0]        bytes_nxt;
   // SDRAM address split
   logic [4:0]       bank_lsb;                // first bank bit
   logic [1:0]       bank_bits;               // 0, 1 or 2 bank bits
   logic [4:0]       row_lsb;                 // first row bit
   logic [10:0]      col_w;                   // column field
   logic [31:0]      bank_shift, row_shift;
   logic [1:0]       bank_w;                  // selected bank
   logic [ROW_W-1:0] row_w;                   // selected row
   logic [ROW_W-1:0] col_pins;                // column on pins
   // column starts at bit 1 and ends at bit 8+size
   assign col_w = req_addr[11:1]
                  & (COL_MASK_FULL >> (PAGE_TOP - page_size_field));
   // bank bits sit just above the column; setting 3 treated as none
   assign bank_lsb  = BANK_LSB_BASE + {3'h0, page_size_field};
   assign bank_bits = (bank_count_field == 2'h2) ? 2'h2 :
                      (bank_count_field == 2'h1) ? 2'h1 : 2'h0;
   assign row_lsb   = bank_lsb + {3'h0, bank_bits};
   assign bank_shift = req_addr >> bank_lsb;
   assign row_shift  = req_addr >> row_lsb;
   // a carry out of the column lands in the bank bits: next bank,
   // same row, column zero
   assign bank_w = bank_shift[1:0]
                   & {bank_bits[1], bank_bits[1] | bank_bits[0]};
   // top row bit only takes part for the large densities
   assign row_w = {row_shift[ROW_W-1] & sdram_large,
                   row_shift[ROW_W-2:0]};
   // A10 held low on column commands so nothing auto-precharges
   assign col_pins = {1'b0, col_w[10], 1'b0, col_w[9:0]};
   // bank trackers
   logic [NBANK-1:0] open_v;
   logic [ROW_W-1:0] open_row [NBANK];
   logic             act_fire, pre_fire;
   logic             row_hit, row_miss;
   assign act_fire = (state_nxt == EMX_ACT);
   assign pre_fire = (state_nxt == EMX_PRE);
   // one tracker per bank; other banks stay open on a move
   for (genvar b = 0; b < NBANK; b++) begin : g_bank
      emx_bank_trk u_trk (
         .clock     (clock),
         .rst_b     (rst_b),
         .open_set  (act_fire && (bank_w == 2'(b))),
         .close_clr (pre_fire && (bank_w == 2'(b))),
         .row_in    (row_w),
         .is_open   (open_v[b]),
         .open_row  (open_row[b])
      );
   end
   // a page is only closed when a different row of its bank is wanted
   assign row_hit  = open_v[bank_w] && (open_row[bank_w] == row_w);
   assign row_miss = open_v[bank_w] && !row_hit;
   // async region decode
   logic ss_w, ew_w, wide_w, nand_w, a22_w;
   logic async_nxt, wait_hold, ph_done;
   logic [ROW_W-1:0] async_pins;
   logic [1:0]       async_ba;
   assign ss_w   = region_strobe_sel[req_region];
   assign ew_w   = region_ext_wait[req_region];
   assign wide_w = region_wide[req_region];
   assign nand_w = region_nand[req_region];
   assign a22_w  = region_a22_en[req_region] & wide_w;
   // A0 carries the word address LSB in every width
   assign async_pins = req_addr[WORD_LSB +: ROW_W];
   // upper bank pin: halfword LSB; lower: byte LSB or A22
   assign async_ba = {req_addr[1],
                      wide_w ? (a22_w & req_addr[A22_SRC])
                             : req_addr[0]};
   assign wait_hold = ew_w && wait_s_r;
   assign ph_done   = (cnt_r == CNT_RST);
   assign async_nxt = (state_nxt == EMX_SETUP) ||
                      (state_nxt == EMX_STROBE) ||
                      (state_nxt == EMX_HOLD);
   // sequencer
   // next state and phase count; ack blocks the held request
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = (cnt_r == CNT_RST) ? CNT_RST : cnt_r - 6'h01;
      unique case (state_r)
         EMX_IDLE: begin
            if (req && !ack && req_sdram) begin
               state_nxt = row_hit  ? EMX_RW  :
                           row_miss ? EMX_PRE : EMX_ACT;
            end else if (req && !ack) begin
               state_nxt = EMX_SETUP;
               cnt_nxt   = setup_cycles;
            end
         end
         EMX_PRE:    state_nxt = EMX_ACT;
         EMX_ACT:    state_nxt = EMX_RW;
         EMX_RW:     state_nxt = EMX_IDLE;
         EMX_SETUP: begin
            if (ph_done) begin
               state_nxt = EMX_STROBE;
               cnt_nxt   = strobe_cycles;
            end
         end
         EMX_STROBE: begin
            // the attached device stretches the strobe with wait
            if (ph_done && !wait_hold) begin
               state_nxt = EMX_HOLD;
               cnt_nxt   = hold_cycles;
            end
         end
         EMX_HOLD: begin
            if (ph_done) state_nxt = EMX_IDLE;
         end
         default: state_nxt = EMX_IDLE;  // illegal code recovers
      endcase
   end

   // pin values for the state being entered
   logic             xfer_end;             // data moves this edge
   logic [1:0]       dqm_nxt;
   logic [NREG-1:0]  cs_nxt;
   logic [ROW_W-1:0] addr_nxt;
   logic [1:0]       ba_nxt;
   assign xfer_end = (state_r == EMX_STROBE) && (state_nxt == EMX_HOLD);
   // SDRAM write masks are the inverse of the lane enables
   assign dqm_nxt =
      (state_nxt == EMX_RW) ? (req_wr ? ~req_be : DQM_READ) :
      async_nxt             ? ~req_be : DQM_IDLE;
   // strobe mode keeps the select off outside the strobe phase
   assign cs_nxt = (async_nxt && (!ss_w || state_nxt == EMX_STROBE))
                   ? ~(4'h1 << req_region) : CS_IDLE;
   assign addr_nxt = (state_nxt == EMX_ACT) ? row_w    :
                     (state_nxt == EMX_RW)  ? col_pins :
                     async_nxt              ? async_pins : '0;
   assign ba_nxt = async_nxt ? async_ba : bank_w;

   // NAND ECC
   logic [DAT_W-1:0] ecc_data;
   logic [16:0]      ecc_a, ecc_b;

   assign ecc_data = req_wr ? req_wdata : din_s_r;

   // column parity in the low byte, odd-byte index xor above it
   function automatic logic [16:0] ecc_step(input logic [16:0] e,
                                            input logic [7:0] d,
                                            input logic [9:0] idx);
      ecc_step = {e[16:8] ^ ((^d) ? idx[8:0] : 9'h000), e[7:0] ^ d};
   endfunction

   assign ecc_a = ecc_step(ecc_value, ecc_data[7:0], ecc_bytes);
   assign ecc_b = ecc_step(ecc_a, ecc_data[15:8], ecc_bytes + 10'h001);

   // only NAND regions feed the code and it stops at the byte limit
   always_comb begin
      ecc_nxt   = ecc_value;
      bytes_nxt = ecc_bytes;
      if (ecc_clear) begin
         ecc_nxt   = '0;
         bytes_nxt = '0;
      end else if (xfer_end && nand_w && ecc_bytes < NAND_MAX) begin
         ecc_nxt   = wide_w ? ecc_b : ecc_a;
         bytes_nxt = ecc_bytes + (wide_w ? 10'h002 : 10'h001);
      end
   end

   // registers
   // pin inputs pass two flops before any logic looks at them
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         wait_m_r <= 1'b0;
         wait_s_r <= 1'b0;
         din_m_r  <= '0;
         din_s_r  <= '0;
      end else begin
         wait_m_r <= wait_input;
         wait_s_r <= wait_m_r;
         din_m_r  <= ext_data_in;
         din_s_r  <= din_m_r;
      end
   end

   // sequencer state and ECC accumulators
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state_r   <= EMX_IDLE;
         cnt_r     <= CNT_RST;
         ecc_value <= '0;
         ecc_bytes <= '0;
      end else begin
         state_r   <= state_nxt;
         cnt_r     <= cnt_nxt;
         ecc_value <= ecc_nxt;
         ecc_bytes <= bytes_nxt;
      end
   end

   // registered commands and handshake
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         sd_cmd_pre   <= 1'b0;
         sd_cmd_act   <= 1'b0;
         sd_cmd_read  <= 1'b0;
         sd_cmd_write <= 1'b0;
         ack          <= 1'b0;
         banks_open   <= '0;
      end else begin
         sd_cmd_pre   <= pre_fire;
         sd_cmd_act   <= act_fire;
         sd_cmd_read  <= (state_nxt == EMX_RW) && !req_wr;
         sd_cmd_write <= (state_nxt == EMX_RW) && req_wr;
         ack          <= (state_r != EMX_IDLE) && (state_nxt == EMX_IDLE);
         banks_open   <= open_v;
      end
   end

   // registered pins; every output leaves from a flop
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         ext_addr_bus           <= '0;
         bank_address_pins      <= '0;
         byte_mask_pins         <= DQM_IDLE;
         region_chip_selects_b  <= CS_IDLE;
         write_strobe_b         <= 1'b1;
         output_enable_strobe_b <= 1'b1;
         ext_data_out           <= '0;
         ext_data_oe_b          <= 1'b1;
         rd_data                <= '0;
      end else begin
         ext_addr_bus           <= addr_nxt;
         bank_address_pins      <= ba_nxt;
         byte_mask_pins         <= dqm_nxt;
         region_chip_selects_b  <= cs_nxt;
         write_strobe_b  <= !(state_nxt == EMX_STROBE && req_wr);
         output_enable_strobe_b <= !(state_nxt == EMX_STROBE && !req_wr);
         ext_data_out           <= req_wdata;
         ext_data_oe_b  <= !(req_wr && (async_nxt || state_nxt == EMX_RW));
         // narrow regions only return the low lane
         if (xfer_end && !req_wr)
            rd_data <= wide_w ? din_s_r : {8'h00, din_s_r[7:0]};
      end
   end

   // checks
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);

   a_read_mask_low: assert property (
      sd_cmd_read |-> byte_mask_pins == DQM_READ)
      else $error("masks not low on read");
   a_write_mask_inv: assert property (
      sd_cmd_write |-> byte_mask_pins == ~req_be)
      else $error("write masks not inverse of enables");
   a_rw_row_open: assert property (
      (sd_cmd_read || sd_cmd_write) |-> open_v[bank_address_pins])
      else $error("column command to closed bank");
   a_act_closed_bank: assert property (
      sd_cmd_act |-> !$past(open_v[bank_w]))
      else $error("activate on bank with open row");
   a_pre_then_act: assert property (
      sd_cmd_pre |=> sd_cmd_act ##1 (sd_cmd_read || sd_cmd_write))
      else $error("precharge not followed by activate");
   a_no_autopre: assert property (
      (sd_cmd_read || sd_cmd_write) |-> !ext_addr_bus[A10_POS])
      else $error("auto-precharge bit set");
   a_row_msb_small: assert property (
      (sd_cmd_act && !sdram_large) |-> !ext_addr_bus[ROW_W-1])
      else $error("top row bit used on small part");
   a_normal_cs_held: assert property (
      (state_r == EMX_SETUP && !ss_w) |->
         !region_chip_selects_b[req_region] [*2])
      else $error("select dropped in normal mode");
   a_strobe_cs_off: assert property (
      (ss_w && (state_r == EMX_SETUP || state_r == EMX_HOLD))
         |-> region_chip_selects_b == CS_IDLE)
      else $error("select active outside strobe");
   a_wait_stretch: assert property (
      (state_r == EMX_STROBE && ph_done && wait_hold)
         |=> state_r == EMX_STROBE)
      else $error("strobe ended while wait held");
   a_ack_pulse: assert property (
      ack |=> !ack)
      else $error("ack longer than one cycle");
endmodule // emx_ctrl
`default_nettype wire

// [dv/emx_mem_model.sv]
// behavioural asynchronous memory on the far side of the region pins
// assumes one region is selected at a time and 16-bit words per entry
`timescale 1ns/100ps
`default_nettype none
module emx_mem_model (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst_b,
   // pins from the controller
   input  wire logic [3:0]  cs_b,
   input  wire logic        we_b,
   input  wire logic        oe_b,
   input  wire logic [12:0] addr,
   input  wire logic [1:0]  ba,
   input  wire logic [15:0] dout,
   // wait cycles raised per strobe, zero answers promptly
   input  wire logic [3:0]  slow,
   // pins back to the controller
   output logic [15:0]      din,
   output logic             wait_o
);
   logic [15:0] mem [0:31];             // small storage array
   logic [15:0] last_r;                 // last value put on the bus
   logic [3:0]  cnt_r;                  // strobe cycles so far
   wire logic       sel = (cs_b != 4'hF);
   wire logic       stb = sel && !(we_b && oe_b);
   wire logic [4:0] idx = {addr[2:0], ba};
   // write on every strobe cycle, the last one wins
   always_ff @(posedge clock) begin
      if (sel && !we_b) mem[idx] <= dout;
   end
   // strobe length counter drives the wait answer
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         cnt_r  <= 4'h0;
         last_r <= 16'h0;
      end else begin
         cnt_r <= stb ? cnt_r + 4'h1 : 4'h0;
         if (sel && !oe_b) last_r <= mem[idx];
      end
   end
   // a released bus shows the inverse, so stale data never looks valid
   assign din    = (sel && !oe_b) ? mem[idx] : ~last_r;
   assign wait_o = stb && (cnt_r < slow);
endmodule // emx_mem_model
`default_nettype wire

// [dv/tb_top.sv]
// self-checking bench for emx_ctrl, one task per scenario
// assumes the package, the controller and the memory model come first
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import emx_pkg::*;
   // stimulus, changed at the falling edge
   logic        clock = 1'b0;
   logic        rst_b = 1'b0;
   logic        req = 1'b0;
   logic        ecl = 1'b0;
   logic        sd = 1'b0;
   logic        wr = 1'b0;
   logic        lg = 1'b1;
   logic [31:0] ad = 32'h0;
   logic [15:0] wdat = 16'h0;
   logic [1:0]  be = 2'h3, rg = 2'h0, bc = 2'h0, ps = 2'h0;
   logic [3:0]  ss = 4'h0, ew = 4'h0, wd = 4'hD, nd = 4'h0, a22 = 4'h1;
   logic [3:0]  slow = 4'h0;
   logic [5:0]  stc = 6'h2;
   logic [5:0]  stu = 6'h0, hdc = 6'h0;
   // outputs seen
   logic        ack, pre, act, rdc, wrc, web, oeb, wai, doeb;
   logic [15:0] rdd, din, dout;
   logic [16:0] ecc;
   logic [9:0]  eb;
   logic [3:0]  bo, csb;
   logic [12:0] ea, r_row, r_col, r_ea;
   logic [1:0]  ba, dqm, r_bk, r_msk, r_ba;
   logic [3:0]  r_cs;
   logic        r_oe;
   int failures = 0, samples_checked = 0, n_pre, n_act, cs_cyc, cs_early;

   always #2 clock = ~clock;

   emx_ctrl DUT (.clock(clock), .rst_b(rst_b), .req(req), .req_sdram(sd),
      .req_wr(wr), .req_addr(ad), .req_be(be), .req_wdata(wdat),
      .req_region(rg), .ack(ack), .rd_data(rdd), .bank_count_field(bc),
      .page_size_field(ps), .sdram_large(lg), .region_strobe_sel(ss),
      .region_ext_wait(ew), .region_wide(wd), .region_nand(nd),
      .region_a22_en(a22), .setup_cycles(stu), .strobe_cycles(stc),
      .hold_cycles(hdc), .ecc_clear(ecl), .ecc_value(ecc),
      .ecc_bytes(eb), .sd_cmd_pre(pre), .sd_cmd_act(act),
      .sd_cmd_read(rdc), .sd_cmd_write(wrc), .banks_open(bo),
      .ext_addr_bus(ea), .bank_address_pins(ba), .byte_mask_pins(dqm),
      .region_chip_selects_b(csb), .write_strobe_b(web),
      .output_enable_strobe_b(oeb), .wait_input(wai),
      .ext_data_in(din), .ext_data_out(dout), .ext_data_oe_b(doeb));

   emx_mem_model MEM (.clock(clock), .rst_b(rst_b), .cs_b(csb),
      .we_b(web), .oe_b(oeb), .addr(ea), .ba(ba), .dout(dout),
      .slow(slow), .din(din), .wait_o(wai));

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         failures++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, s, e);
      end
   endtask

   task automatic give_verdict;
      $display("compares %0d, mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic reset_dut;
      rst_b = 1'b0;
      repeat (10) @(negedge clock);
      rst_b = 1'b1;
   endtask

   // one request held until ack; pins and commands captured on the way
   task automatic go(input logic s, input logic w, input logic [31:0] a,
                     input logic [1:0] b, input logic [1:0] r);
      int n;
      @(negedge clock);
      {sd, wr, ad, be, rg} = {s, w, a, b, r};
      req = 1'b1;
      n_pre = 0;
      n_act = 0;
      cs_cyc = 0;
      cs_early = 0;
      for (n = 0; n < 300 && ack !== 1'b1; n++) begin
         @(posedge clock);
         #1;
         if (pre === 1'b1) n_pre++;
         if (act === 1'b1) begin
            {r_row, r_bk} = {ea, ba};
            n_act++;
         end
         if (rdc === 1'b1 || wrc === 1'b1) {r_col, r_msk} = {ea, dqm};
         if (csb !== CS_IDLE) begin
            {r_cs, r_ea, r_ba, r_msk, r_oe} = {csb, ea, ba, dqm, doeb};
            cs_cyc++;
            if (web === 1'b1 && oeb === 1'b1) cs_early++;
         end
      end
      if (ack !== 1'b1) begin
         failures++;
         give_verdict();
      end
      @(negedge clock);
      req = 1'b0;
   endtask

   // bank-count settings 0 to 2 with every page size, last column of a page
   task automatic t_map;
      logic [10:0] c;
      logic [31:0] a;
      for (int p = 0; p < 4; p++) begin
         for (int b = 0; b < 3; b++) begin
            {ps, bc} = {2'(p), 2'(b)};
            c = 11'((32'h1 << (8 + p)) - 1);
            a = (32'(p * 3 + b + 1) << (9 + p + b)) | {20'h0, c, 1'b0};
            a = a | (32'(b) << (9 + p));
            go(1'b1, 1'b0, a, 2'h3, 2'h0);
            chk(r_row, p * 3 + b + 1);
            chk(r_bk, b);
            chk(r_col, {2'b00, c[10], 1'b0, c[9:0]});
            chk(r_msk, 2'h0);
         end
      end
      $display("test map done");
   endtask

   // page walk across banks, open pages, conflicts, masks, top row bit
   task automatic t_walk;
      logic [31:0] a0;
      reset_dut();
      {bc, ps} = {2'h2, 2'h0};
      a0 = 32'h29FE;
      go(1'b1, 1'b0, a0 - 32'h2, 2'h3, 2'h0);
      chk(r_col, 13'h0FE);
      go(1'b1, 1'b0, a0, 2'h3, 2'h0);
      chk(n_act, 0);
      chk(r_col, 13'h0FF);
      go(1'b1, 1'b0, a0 + 32'h2, 2'h3, 2'h0);
      chk({r_row, r_bk, r_col}, {13'h5, 2'h1, 13'h0});
      chk(bo, 4'h3);
      go(1'b1, 1'b0, a0, 2'h3, 2'h0);
      chk(n_act + n_pre, 0);
      go(1'b1, 1'b0, a0 + 32'h800, 2'h3, 2'h0);
      chk(n_pre, 1);
      chk(n_act, 1);
      go(1'b1, 1'b1, a0 + 32'h2, 2'h1, 2'h0);
      chk(r_msk, 2'h2);
      lg = 1'b0;
      go(1'b1, 1'b0, 32'h0082_8400, 2'h3, 2'h0);
      chk(r_row, 13'h0050);
      lg = 1'b1;
      $display("test walk done");
   endtask

   // normal mode on a 16-bit region with line 22, then an 8-bit region
   task automatic t_async;
      reset_dut();
      wdat = 16'hA55A;
      go(1'b0, 1'b1, 32'h0100_0006, 2'h3, 2'h0);
      chk(r_cs, 4'hE);
      chk(cs_early > 0, 1);
      chk({r_ea, r_ba, r_msk}, {13'h1, 2'h3, 2'h0});
      chk(r_oe, 1'b0);
      go(1'b0, 1'b0, 32'h0100_0006, 2'h3, 2'h0);
      chk(rdd, 16'hA55A);
      wdat = 16'h00C3;
      go(1'b0, 1'b1, 32'hB, 2'h3, 2'h1);
      chk({r_ea, r_ba}, {13'h2, 2'h3});
      {stu, hdc} = {6'h1, 6'h1};
      go(1'b0, 1'b0, 32'hB, 2'h1, 2'h1);
      {stu, hdc} = {6'h0, 6'h0};
      chk(rdd, 16'h00C3);
      chk(r_msk, 2'h2);
      chk(r_oe, 1'b1);
      chk(cs_cyc, 7);
      $display("test async done");
   endtask

   // strobe-select region, slow wait answer, then ECC on a NAND region
   task automatic t_strobe;
      int c0;
      reset_dut();
      ss = 4'h4;
      wdat = 16'h1234;
      go(1'b0, 1'b1, 32'h10, 2'h3, 2'h2);
      chk(cs_early, 0);
      chk(r_cs, 4'hB);
      go(1'b0, 1'b0, 32'h10, 2'h1, 2'h2);
      chk({rdd, r_msk}, {16'h1234, 2'h2});
      c0 = cs_cyc;
      {ew, slow} = {4'h4, 4'h6};
      go(1'b0, 1'b0, 32'h10, 2'h3, 2'h2);
      chk(cs_cyc > c0, 1);
      chk(rdd, 16'h1234);
      {ew, slow, nd} = {4'h0, 4'h0, 4'h8};
      ecl = 1'b1;
      @(negedge clock);
      ecl = 1'b0;
      wdat = 16'h3D5A;
      go(1'b0, 1'b1, 32'h20, 2'h3, 2'h3);
      chk({eb, ecc}, {10'h2, 17'h00167});
      $display("test strobe done");
   endtask

   initial begin
      reset_dut();
      t_map();
      t_walk();
      t_async();
      t_strobe();
      give_verdict();
   end
endmodule // tb_top
`default_nettype wire
